// ### verilog/rx_monitor_pkg.sv
// Package of constants and types for the receive status and statistics monitor
// Summary of operation
// - Block lock flag follows achieved block delineation
// - High error flag at sixteen bad headers
// - Link ok is lock without high error
// - Interval strobe every 125 us, publishes count
// - Eight-bit count of bad-header words per interval
// - Published count changes only on strobe
// - Published count never exceeds sixteen
// - Pattern strobe on every count refresh
// - Eight-bit pattern error counter in PRBS and pseudo test modes only
// - Outside test modes count zero, no strobe
// - Errored-block strobe on decoder error entry
// - Zero select picks zeros or local faults
// - Raw word inputs used only in backplane variant
// - Pattern enable enters test mode, type selects
package rx_monitor_pkg;
  localparam int unsigned clk_hz = 10000000;
  localparam int unsigned interval_us = 125;
  localparam int unsigned interval_cycles = (interval_us * (clk_hz / 1000000));
  localparam logic [7:0] bad_header_limit = 8'h10;
  localparam logic [7:0] count_reset = 8'h00;
  localparam int unsigned lock_good_needed = 64;
  localparam int unsigned lock_bad_limit = 16;
  localparam int unsigned pattern_window_cycles = 128;
  localparam logic [1:0] sync_data = 2'h1;
  localparam logic [1:0] sync_ctrl = 2'h2;
  localparam logic [63:0] local_fault_pair = 64'h0100_0000_0100_009C;
  localparam logic [15:0] square_pattern = 16'hF0F0;
  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_prbs = 2'b01,
    mode_pseudo = 2'b10,
    mode_square = 2'b11
  } test_mode_t;
endpackage

// ### verilog/rx_event_if.sv
// Interface carrying per-word receive events between monitor modules
`timescale 1ns/1ps
interface rx_event_if;
  logic word_valid;
  logic bad_header;
  logic pattern_error;
  logic block_error;
  logic test_active;
  modport source (output word_valid, bad_header, pattern_error, block_error, test_active);
  modport sink (input word_valid, bad_header, pattern_error, block_error, test_active);
endinterface

// ### verilog/rx_word_checker.sv
// Per-word checker: sync header and test pattern comparison
`timescale 1ns/1ps
module rx_word_checker #(
  parameter int word_width = 64
) (
  input wire logic clk, // Core clock
  input wire logic reset, // Asynchronous reset
  input wire logic rx_sync_reset, // Synchronous receive reset
  input wire logic [word_width+1:0] word_in, // Header and payload
  input wire logic word_in_valid, // Word qualifier
  input wire rx_monitor_pkg::test_mode_t mode, // Active test mode
  input wire logic pattern_zero_data_select, // Zero data pattern select
  rx_event_if.source ev // Events out
);
  logic [30:0] prbs_reg, prbs_next;
  logic [word_width-1:0] expect_word;
  logic [1:0] hdr;

  // Expected test data and header extraction
  always_comb
  begin
    hdr = word_in[word_width+1:word_width];
    expect_word = pattern_zero_data_select ? '0 :
      rx_monitor_pkg::local_fault_pair[word_width-1:0];
    if (mode == rx_monitor_pkg::mode_square)
      expect_word = {(word_width/16){rx_monitor_pkg::square_pattern}};
    prbs_next = prbs_reg;
    if (word_in_valid && mode == rx_monitor_pkg::mode_prbs)
      prbs_next = word_in[30:0]; // Self-synchronising seed
  end

  // Event registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prbs_reg <= '0;
      ev.word_valid <= 1'b0;
      ev.bad_header <= 1'b0;
      ev.pattern_error <= 1'b0;
      ev.block_error <= 1'b0;
      ev.test_active <= 1'b0;
    end
    else if (rx_sync_reset)
    begin
      prbs_reg <= '0;
      ev.word_valid <= 1'b0;
      ev.bad_header <= 1'b0;
      ev.pattern_error <= 1'b0;
      ev.block_error <= 1'b0;
      ev.test_active <= 1'b0;
    end
    else
    begin
      prbs_reg <= prbs_next;
      ev.word_valid <= word_in_valid;
      ev.bad_header <= word_in_valid && (hdr != rx_monitor_pkg::sync_data) &&
        (hdr != rx_monitor_pkg::sync_ctrl);
      ev.test_active <= (mode == rx_monitor_pkg::mode_prbs) ||
        (mode == rx_monitor_pkg::mode_pseudo);
      ev.block_error <= word_in_valid && mode == rx_monitor_pkg::mode_normal &&
        hdr == rx_monitor_pkg::sync_ctrl && word_in[7:0] == 8'h00;
      ev.pattern_error <= word_in_valid && (
        (mode == rx_monitor_pkg::mode_prbs &&
          word_in[61:31] != {prbs_reg[27:0] ^ prbs_reg[30:3], prbs_reg[2:0]}) ||
        (mode == rx_monitor_pkg::mode_pseudo && word_in[word_width-1:0] != expect_word) ||
        (mode == rx_monitor_pkg::mode_square && word_in[word_width-1:0] != expect_word));
    end
  end
endmodule

// ### verilog/rx_status_monitor.sv
// Top module: receive status, error-ratio and test statistics
`timescale 1ns/1ps
module rx_status_monitor #(
  parameter int backplane_variant_param = 1, // One enables use of the raw word inputs
  parameter int word_width = 64 // Raw word width, 32 or 64
) (
  input wire logic clk, // Receive core clock
  input wire logic reset, // Asynchronous reset
  input wire logic rx_sync_reset, // Synchronous receive reset
  input wire logic serial_rx_word_ready, // Lane ready
  input wire logic serial_rx_word_valid, // Word valid
  input wire logic [word_width+1:0] serial_rx_word, // Header plus payload
  input wire logic rx_prbs_test_enable, // PRBS31 check mode
  input wire logic rx_pattern_test_enable, // Pattern check mode
  input wire logic rx_pattern_type_select, // High square, low pseudo
  input wire logic pattern_zero_data_select, // Zero data select
  output logic rx_block_lock_flag, // Block lock
  output logic high_error_ratio_flag, // High error ratio
  output logic rx_link_ok, // Link status
  output logic error_ratio_interval_strobe, // Interval strobe
  output logic [7:0] interval_bad_header_count, // Published count
  output logic pattern_check_update_strobe, // Pattern count update
  output logic [7:0] pattern_check_error_count, // Pattern errors
  output logic errored_block_strobe // Errored block
);
  rx_event_if ev ();
  rx_monitor_pkg::test_mode_t mode;
  logic ready_s1_reg, ready_s2_reg, valid_s1_reg, valid_s2_reg;
  logic [word_width+1:0] word_s1_reg, word_s2_reg;
  logic word_ok;
  // Configuration pins after two synchroniser stages
  logic prbs_s1_reg, prbs_s2_reg, pat_en_s1_reg, pat_en_s2_reg;
  logic type_s1_reg, type_s2_reg, zero_s1_reg, zero_s2_reg;

  // Statistics state and next values
  logic [7:0] good_reg, good_next, badc_reg, badc_next;
  logic lock_reg, lock_next;
  logic [15:0] timer_reg, timer_next;
  logic [7:0] ber_reg, ber_next, pub_reg, pub_next;
  logic hiber_reg, hiber_next, istrb_reg, istrb_next;
  logic [7:0] pat_reg, pat_next, patpub_reg, patpub_next;
  logic [7:0] pwin_reg, pwin_next;
  logic pstrb_reg, pstrb_next, eblk_reg, eblk_next, eprev_reg, eprev_next;

  // Last count of the interval timer
  localparam logic [15:0] timer_last = 16'(rx_monitor_pkg::interval_cycles - 1);

  // Saturating eight-bit increment
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic [7:0] cap);
    sat_inc = (v >= cap) ? cap : 8'(v + 8'h01);
  endfunction

  // Two-stage synchronisers for lane inputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
      word_s1_reg <= '0;
      word_s2_reg <= '0;
    end
    else
    begin
      ready_s1_reg <= serial_rx_word_ready;
      ready_s2_reg <= ready_s1_reg;
      valid_s1_reg <= serial_rx_word_valid;
      valid_s2_reg <= valid_s1_reg;
      word_s1_reg <= serial_rx_word;
      word_s2_reg <= word_s1_reg;
    end
  end

  // Two-stage synchronisers for the test configuration pins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prbs_s1_reg <= 1'b0;
      prbs_s2_reg <= 1'b0;
      pat_en_s1_reg <= 1'b0;
      pat_en_s2_reg <= 1'b0;
      type_s1_reg <= 1'b0;
      type_s2_reg <= 1'b0;
      zero_s1_reg <= 1'b0;
      zero_s2_reg <= 1'b0;
    end
    else
    begin
      prbs_s1_reg <= rx_prbs_test_enable;
      prbs_s2_reg <= prbs_s1_reg;
      pat_en_s1_reg <= rx_pattern_test_enable;
      pat_en_s2_reg <= pat_en_s1_reg;
      type_s1_reg <= rx_pattern_type_select;
      type_s2_reg <= type_s1_reg;
      zero_s1_reg <= pattern_zero_data_select;
      zero_s2_reg <= zero_s1_reg;
    end
  end

  // Raw inputs are used only in the backplane variant
  always_comb
  begin
    word_ok = (backplane_variant_param == 1) && ready_s2_reg && valid_s2_reg;
  end

  // Test mode decode; PRBS has the highest priority
  always_comb
  begin
    if (prbs_s2_reg)
      mode = rx_monitor_pkg::mode_prbs;
    else if (pat_en_s2_reg)
      mode = type_s2_reg ? rx_monitor_pkg::mode_square :
        rx_monitor_pkg::mode_pseudo;
    else
      mode = rx_monitor_pkg::mode_normal;
  end

  rx_word_checker #(.word_width(word_width)) checker_u (
    .clk(clk),
    .reset(reset),
    .rx_sync_reset(rx_sync_reset),
    .word_in(word_s2_reg),
    .word_in_valid(word_ok),
    .mode(mode),
    .pattern_zero_data_select(zero_s2_reg),
    .ev(ev)
  );

  // Block lock: run of good headers gains, burst of bad headers loses
  always_comb
  begin
    good_next = good_reg;
    badc_next = badc_reg;
    lock_next = lock_reg;
    if (ev.word_valid)
    begin
      if (ev.bad_header)
      begin
        good_next = 8'h00;
        badc_next = sat_inc(badc_reg, 8'(rx_monitor_pkg::lock_bad_limit));
        if (badc_next >= 8'(rx_monitor_pkg::lock_bad_limit))
          lock_next = 1'b0;
      end
      else
      begin
        good_next = sat_inc(good_reg, 8'(rx_monitor_pkg::lock_good_needed));
        if (good_next >= 8'(rx_monitor_pkg::lock_good_needed))
        begin
          lock_next = 1'b1;
          badc_next = 8'h00;
        end
      end
    end
  end

  // Error ratio interval timer and bad-header counting
  always_comb
  begin
    timer_next = (timer_reg == timer_last) ? 16'h0000 : 16'(timer_reg + 16'h0001);
    istrb_next = (timer_reg == timer_last);
    ber_next = ber_reg;
    if (ev.word_valid && ev.bad_header)
      ber_next = sat_inc(ber_reg, rx_monitor_pkg::bad_header_limit);
    // Flag sets as soon as the count reaches the limit, then holds
    hiber_next = hiber_reg || (ber_next >= rx_monitor_pkg::bad_header_limit);
    pub_next = pub_reg;
    if (istrb_next)
    begin
      pub_next = ber_next;
      ber_next = rx_monitor_pkg::count_reset;
      // Clear only at an interval end whose count stayed below the limit
      if (pub_next < rx_monitor_pkg::bad_header_limit)
        hiber_next = 1'b0;
    end
  end

  // Pattern error counting and periodic refresh
  always_comb
  begin
    pat_next = pat_reg;
    patpub_next = patpub_reg;
    pstrb_next = 1'b0;
    pwin_next = pwin_reg;
    if (!ev.test_active)
    begin
      pat_next = rx_monitor_pkg::count_reset;
      patpub_next = rx_monitor_pkg::count_reset;
      pwin_next = 8'h00;
    end
    else
    begin
      if (ev.pattern_error)
        pat_next = sat_inc(pat_reg, 8'hFF);
      pwin_next = 8'(pwin_reg + 8'h01);
      if (pwin_reg == 8'(rx_monitor_pkg::pattern_window_cycles - 1))
      begin
        pwin_next = 8'h00;
        pstrb_next = 1'b1;
        patpub_next = pat_next;
      end
    end
  end

  // Errored-block strobe on each rising edge of a decoder error
  always_comb
  begin
    eprev_next = ev.block_error;
    eblk_next = ev.block_error && !eprev_reg && !ev.test_active;
  end

  // State registers; reset clears all
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      good_reg <= 8'h00;
      badc_reg <= 8'h00;
      lock_reg <= 1'b0;
      timer_reg <= 16'h0000;
      ber_reg <= 8'h00;
      pub_reg <= 8'h00;
      hiber_reg <= 1'b0;
      istrb_reg <= 1'b0;
      pat_reg <= 8'h00;
      patpub_reg <= 8'h00;
      pwin_reg <= 8'h00;
      pstrb_reg <= 1'b0;
      eblk_reg <= 1'b0;
      eprev_reg <= 1'b0;
    end
    else if (rx_sync_reset)
    begin
      good_reg <= 8'h00;
      badc_reg <= 8'h00;
      lock_reg <= 1'b0;
      timer_reg <= 16'h0000;
      ber_reg <= 8'h00;
      pub_reg <= 8'h00;
      hiber_reg <= 1'b0;
      istrb_reg <= 1'b0;
      pat_reg <= 8'h00;
      patpub_reg <= 8'h00;
      pwin_reg <= 8'h00;
      pstrb_reg <= 1'b0;
      eblk_reg <= 1'b0;
      eprev_reg <= 1'b0;
    end
    else
    begin
      good_reg <= good_next;
      badc_reg <= badc_next;
      lock_reg <= lock_next;
      timer_reg <= timer_next;
      ber_reg <= ber_next;
      pub_reg <= pub_next;
      hiber_reg <= hiber_next;
      istrb_reg <= istrb_next;
      pat_reg <= pat_next;
      patpub_reg <= patpub_next;
      pwin_reg <= pwin_next;
      pstrb_reg <= pstrb_next;
      eblk_reg <= eblk_next;
      eprev_reg <= eprev_next;
    end
  end

  // Output flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_block_lock_flag <= 1'b0;
      high_error_ratio_flag <= 1'b0;
      rx_link_ok <= 1'b0;
      error_ratio_interval_strobe <= 1'b0;
      interval_bad_header_count <= 8'h00;
      pattern_check_update_strobe <= 1'b0;
      pattern_check_error_count <= 8'h00;
      errored_block_strobe <= 1'b0;
    end
    else if (rx_sync_reset)
    begin
      rx_block_lock_flag <= 1'b0;
      high_error_ratio_flag <= 1'b0;
      rx_link_ok <= 1'b0;
      error_ratio_interval_strobe <= 1'b0;
      interval_bad_header_count <= 8'h00;
      pattern_check_update_strobe <= 1'b0;
      pattern_check_error_count <= 8'h00;
      errored_block_strobe <= 1'b0;
    end
    else
    begin
      rx_block_lock_flag <= lock_reg;
      high_error_ratio_flag <= hiber_reg;
      rx_link_ok <= lock_reg && !hiber_reg;
      error_ratio_interval_strobe <= istrb_reg;
      interval_bad_header_count <= pub_reg;
      pattern_check_update_strobe <= pstrb_reg && ev.test_active;
      pattern_check_error_count <= ev.test_active ? patpub_reg : 8'h00;
      errored_block_strobe <= eblk_reg;
    end
  end
endmodule

// ### tb/rx_status_monitor_checker.sv
// Port checker for the receive status monitor
`timescale 1ns/1ps
module rx_status_monitor_checker (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic rx_sync_reset, // Sync reset
  input wire logic rx_prbs_test_enable, // PRBS mode
  input wire logic rx_pattern_test_enable, // Pattern mode
  input wire logic rx_block_lock_flag, // Lock
  input wire logic high_error_ratio_flag, // High error
  input wire logic rx_link_ok, // Link
  input wire logic error_ratio_interval_strobe, // Interval
  input wire logic [7:0] interval_bad_header_count, // Count
  input wire logic pattern_check_update_strobe, // Pattern strobe
  input wire logic [7:0] pattern_check_error_count, // Pattern count
  input wire logic errored_block_strobe // Errored block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [11:0] gap_reg;
  logic [11:0] gap_next;
  logic seen_reg;
  logic seen_next;
  wire test_on = rx_prbs_test_enable || rx_pattern_test_enable;
  wire link_cause = rx_block_lock_flag && !high_error_ratio_flag;
  // Cycles since the last interval strobe
  always_comb
  begin
    gap_next = error_ratio_interval_strobe ? 12'h000 : gap_reg + 12'h001;
    seen_next = (seen_reg || error_ratio_interval_strobe) && !rx_sync_reset;
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gap_reg <= 12'h000;
      seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= gap_next;
      seen_reg <= seen_next;
    end
  end
  AST_LINK_UP: assert property (link_cause [*2] |-> rx_link_ok)
    else $error("link ok missing");
  AST_LINK_DOWN: assert property (!link_cause [*2] |-> !rx_link_ok)
    else $error("link ok without cause");
  AST_HI_SET: assert property (error_ratio_interval_strobe &&
    interval_bad_header_count == 8'h10 |-> high_error_ratio_flag) else $error("high flag low");
  AST_HI_CLEAR: assert property (error_ratio_interval_strobe &&
    interval_bad_header_count < 8'h10 |-> ##[1:2] !high_error_ratio_flag)
    else $error("high flag stuck");
  AST_PERIOD: assert property (seen_reg && error_ratio_interval_strobe |->
    gap_reg == 12'h4E1) else $error("interval length wrong");
  AST_PERIOD_MAX: assert property (seen_reg |-> gap_reg < 12'h4E2)
    else $error("interval strobe late");
  AST_CNT_HOLD: assert property (!error_ratio_interval_strobe && !rx_sync_reset &&
    !$past(rx_sync_reset) |-> $stable(interval_bad_header_count)) else $error("count moved");
  AST_CNT_MAX: assert property (interval_bad_header_count <= 8'h10)
    else $error("count above ceiling");
  AST_PAT_OFF: assert property (!test_on [*6] |-> pattern_check_error_count == 8'h00
    && !pattern_check_update_strobe) else $error("pattern count outside test");
  AST_BLOCK_NORMAL: assert property (test_on [*6] |-> !errored_block_strobe)
    else $error("errored block in test mode");
  AST_BLOCK_PULSE: assert property (errored_block_strobe |=> !errored_block_strobe)
    else $error("errored block strobe too long");
  AST_SYNC_CLEAR: assert property (rx_sync_reset |-> ##2 !rx_block_lock_flag &&
    !rx_link_ok && interval_bad_header_count == 8'h00) else $error("sync reset ignored");
  cover property (error_ratio_interval_strobe && interval_bad_header_count == 8'h10);
  cover property ($rose(rx_link_ok));
  cover property (errored_block_strobe);
  cover property (pattern_check_update_strobe);
endmodule

// ### tb/rx_lane_model.sv
// Receive lane model launching coded words on command
`timescale 1ns/1ps
module rx_lane_model #(
  parameter int word_width = 64 // Payload width
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic [1:0] kind, // 0 idle 1 data 2 bad 3 errored
  output logic serial_rx_word_ready, // Ready
  output logic serial_rx_word_valid, // Valid
  output logic [word_width+1:0] serial_rx_word // Word
);
  logic [word_width-1:0] seq_reg;
  // One word per cycle, launched off the sampling edge
  always @(negedge clk or posedge reset)
  begin
    if (reset)
    begin
      serial_rx_word_ready <= 1'b0;
      serial_rx_word_valid <= 1'b0;
      serial_rx_word <= '0;
      seq_reg <= '0;
    end
    else
    begin
      serial_rx_word_ready <= 1'b1;
      serial_rx_word_valid <= (kind != 2'h0);
      seq_reg <= seq_reg + {{(word_width-1){1'b0}}, 1'b1};
      case (kind)
        2'h1: serial_rx_word <= {rx_monitor_pkg::sync_data, seq_reg};
        2'h2: serial_rx_word <= {2'h0, seq_reg};
        2'h3: serial_rx_word <= {rx_monitor_pkg::sync_ctrl, seq_reg[word_width-1:8], 8'h00};
        default: serial_rx_word <= ~serial_rx_word; // Idle lane is never stable
      endcase
    end
  end
endmodule

// ### tb/rx_status_monitor_bench.sv
// Self-checking bench for the receive status monitor
`timescale 1ns/1ps
module rx_status_monitor_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rx_sync_reset = 1'b0;
  logic rx_prbs_test_enable = 1'b0;
  logic rx_pattern_test_enable = 1'b0;
  logic rx_pattern_type_select = 1'b0;
  logic pattern_zero_data_select = 1'b0;
  logic [1:0] kind = 2'h0;
  logic serial_rx_word_ready, serial_rx_word_valid;
  logic [65:0] serial_rx_word;
  logic rx_block_lock_flag, high_error_ratio_flag, rx_link_ok;
  logic error_ratio_interval_strobe, pattern_check_update_strobe, errored_block_strobe;
  logic [7:0] interval_bad_header_count, pattern_check_error_count;
  logic seen;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  rx_lane_model LANE (.clk, .reset, .kind, .serial_rx_word_ready, .serial_rx_word_valid,
    .serial_rx_word);
  rx_status_monitor #(.backplane_variant_param(1), .word_width(64)) DUT (.clk, .reset,
    .rx_sync_reset, .serial_rx_word_ready, .serial_rx_word_valid, .serial_rx_word,
    .rx_prbs_test_enable, .rx_pattern_test_enable, .rx_pattern_type_select,
    .pattern_zero_data_select, .rx_block_lock_flag, .high_error_ratio_flag, .rx_link_ok,
    .error_ratio_interval_strobe, .interval_bad_header_count, .pattern_check_update_strobe,
    .pattern_check_error_count, .errored_block_strobe);
  // Clock at 100 ns period
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Compare one value
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Hold a word kind for n cycles
  task automatic send(input logic [1:0] k, input int n);
    repeat (n)
    begin
      kind <= k;
      @(negedge clk);
    end
  endtask
  // Wait for a strobe: 0 interval, 1 pattern, 2 errored block
  task automatic await(input int sel, input int limit);
    seen = 1'b0;
    repeat (limit)
    begin
      @(negedge clk);
      if ((sel == 0 ? error_ratio_interval_strobe : sel == 1 ?
          pattern_check_update_strobe : errored_block_strobe) === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask
  // Final counts and verdict
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Test sequence
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("lock in reset", 8'h00, {7'h00, rx_block_lock_flag});
    chk("count in reset", 8'h00, interval_bad_header_count);
    reset = 1'b0;
    send(2'h1, 80);
    chk("lock", 8'h01, {7'h00, rx_block_lock_flag});
    chk("link", 8'h01, {7'h00, rx_link_ok});
    $display("test lock done");
    await(0, 1300);
    chk("interval strobe", 8'h01, {7'h00, seen});
    repeat (5)
    begin
      send(2'h2, 1);
      send(2'h1, 3);
    end
    await(0, 1300);
    chk("five bad headers", 8'h05, interval_bad_header_count);
    await(0, 1300);
    chk("quiet interval", 8'h00, interval_bad_header_count);
    $display("test count done");
    repeat (20)
    begin
      send(2'h2, 1);
      send(2'h1, 1);
    end
    send(2'h1, 8);
    chk("high flag", 8'h01, {7'h00, high_error_ratio_flag});
    chk("link in high", 8'h00, {7'h00, rx_link_ok});
    await(0, 1300);
    chk("capped count", 8'h10, interval_bad_header_count);
    await(0, 1300);
    send(2'h1, 80);
    chk("high cleared", 8'h00, {7'h00, high_error_ratio_flag});
    chk("link back", 8'h01, {7'h00, rx_link_ok});
    $display("test high error done");
    send(2'h3, 1);
    kind <= 2'h1;
    await(2, 10);
    chk("errored block", 8'h01, {7'h00, seen});
    $display("test errored block done");
    for (int i = 0; i < 4; i++)
    begin
      rx_prbs_test_enable = (i == 0);
      rx_pattern_test_enable = (i != 0);
      pattern_zero_data_select = (i == 1);
      rx_pattern_type_select = (i == 3);
      send(2'h3, 2);
      send(2'h1, 2);
      await(1, 300);
      chk("pattern strobe", {7'h00, i < 3}, {7'h00, seen});
      if (i != 0)
        chk("pattern errors", (i == 3) ? 8'h00 : 8'h80, pattern_check_error_count);
      rx_prbs_test_enable = 1'b0;
      rx_pattern_test_enable = 1'b0;
      send(2'h1, 10);
      chk("pattern count off", 8'h00, pattern_check_error_count);
    end
    $display("test pattern modes done");
    rx_sync_reset = 1'b1;
    @(negedge clk);
    rx_sync_reset = 1'b0;
    send(2'h0, 3);
    chk("lock after sync reset", 8'h00, {7'h00, rx_block_lock_flag});
    chk("link after sync reset", 8'h00, {7'h00, rx_link_ok});
    $display("test sync reset done");
    conclude();
  end
endmodule
bind rx_status_monitor rx_status_monitor_checker CHK (.clk, .reset, .rx_sync_reset,
  .rx_prbs_test_enable, .rx_pattern_test_enable, .rx_block_lock_flag, .high_error_ratio_flag,
  .rx_link_ok, .error_ratio_interval_strobe, .interval_bad_header_count,
  .pattern_check_update_strobe, .pattern_check_error_count, .errored_block_strobe);
